// file: verilog/mpf_pkg.sv
// Package of constants and carrier types for the pause flow-control block
package mpf_pkg;
    localparam int          MPF_MAX_Q      = 8;
    localparam int          MPF_QUANTA_W   = 16;
    localparam int          MPF_CYC_PER_Q  = 8;
    localparam int          MPF_CYC_SHIFT  = 3;
    localparam int          MPF_TMR_W      = MPF_QUANTA_W + MPF_CYC_SHIFT;
    localparam int          MPF_ADDR_W     = 4;
    // Register byte offsets
    localparam logic [3:0]  MPF_OFS_TXCTRL = 4'h0;
    localparam logic [3:0]  MPF_OFS_STATUS = 4'h4;
    localparam logic [3:0]  MPF_OFS_DUR    = 4'h8;
    localparam logic [3:0]  MPF_OFS_CFG    = 4'hC;
    // Field positions
    localparam int          MPF_CTRL_XON   = 0;
    localparam int          MPF_CTRL_XOFF  = 1;
    localparam int          MPF_REQ_XON    = 0;
    localparam int          MPF_REQ_XOFF   = 1;
    localparam int          MPF_ST_PAUSED  = 8;
    localparam int          MPF_CFG_PFC    = 8;
    localparam int          MPF_CFG_TXONLY = 9;
    // Reset values
    localparam logic [1:0]  MPF_RST_CTRL   = 2'h0;
    localparam logic [31:0] MPF_RST_WORD   = 32'h0000_0000;
    localparam logic [MPF_TMR_W-1:0] MPF_RST_TMR = '0;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } mpf_mm_req_t;

    typedef struct packed {
        logic                                   valid;
        logic [MPF_MAX_Q-1:0]                   enable;
        logic [MPF_MAX_Q-1:0][MPF_QUANTA_W-1:0] quanta;
    } mpf_pfc_frame_t;

    typedef struct packed {
        logic xoff;
        logic xon;
    } mpf_pause_gen_t;

    typedef enum logic [0:0] {
        MPF_BUS_IDLE,
        MPF_BUS_ACK
    } mpf_bus_st_t;
endpackage : mpf_pkg

// file: verilog/mpf_flow_ctrl.sv
// Pause and priority flow-control sideband logic with a register slave
module mpf_flow_ctrl #(
    parameter bit PFC_EN  = 1'b1,             // Priority flow control built
    parameter int NUM_Q   = 8,                // Priority queues, 2 to 8
    parameter bit TX_ONLY = 1'b0              // Transmit-only build variant
) (
    input  wire logic                            clk_i,          // Client clock
    input  wire logic                            rst_b_i,        // Async reset, low
    input  wire mpf_pkg::mpf_mm_req_t            mm_i,           // Register bus request
    output logic [31:0]                          mm_readdata_o,  // Register read data
    output logic                                 mm_waitrequest_o, // Bus stall
    input  wire logic [1:0]                      pause_frame_request_i, // XON/XOFF ask
    output mpf_pkg::mpf_pause_gen_t              pause_gen_o,    // Pause frame command
    input  wire mpf_pkg::mpf_pfc_frame_t         rx_pfc_frame_i, // Parsed PFC frame
    output logic [mpf_pkg::MPF_MAX_Q-1:0]        rx_priority_pause_flags_o, // Per queue
    input  wire logic [2*mpf_pkg::MPF_MAX_Q-1:0] tx_priority_xon_xoff_request_i, // Pairs
    output logic [mpf_pkg::MPF_MAX_Q-1:0]        tx_pfc_xon_o,   // Per queue XON
    output logic [mpf_pkg::MPF_MAX_Q-1:0]        tx_pfc_xoff_o,  // Per queue XOFF
    input  wire logic [15:0]                     rx_pause_duration_in_i, // Quanta
    input  wire logic                            rx_pause_duration_valid_i, // Qualifier
    output logic                                 tx_paused_o     // Transmit held off
);
    import mpf_pkg::*;

    localparam logic [MPF_MAX_Q-1:0] Q_MASK = MPF_MAX_Q'((1 << NUM_Q) - 1);

    function automatic logic [MPF_TMR_W-1:0] quanta_to_cycles(input logic [15:0] q);
        quanta_to_cycles = {q, {MPF_CYC_SHIFT{1'b0}}};
    endfunction

    function automatic logic [MPF_TMR_W-1:0] tmr_step(input logic [MPF_TMR_W-1:0] t);
        tmr_step = (t != MPF_RST_TMR) ? t - MPF_TMR_W'(1) : t;
    endfunction

    // Register bus slave: one wait state on every access
    mpf_bus_st_t    bus_st_r;
    logic           acc_req;
    logic           wr_take;
    logic [31:0]    rd_nxt;
    logic [1:0]     sw_pend_r;
    logic [15:0]    dur_r;

    assign acc_req          = mm_i.read | mm_i.write;
    assign mm_waitrequest_o = acc_req & (bus_st_r == MPF_BUS_IDLE);
    assign wr_take          = mm_i.write & (bus_st_r == MPF_BUS_ACK);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_st_r <= MPF_BUS_IDLE;
        end else begin
            case (bus_st_r)
                MPF_BUS_IDLE: bus_st_r <= acc_req ? MPF_BUS_ACK : MPF_BUS_IDLE;
                MPF_BUS_ACK:  bus_st_r <= MPF_BUS_IDLE;
                default:      bus_st_r <= MPF_BUS_IDLE;
            endcase
        end
    end

    always_comb begin
        rd_nxt = MPF_RST_WORD;
        case (mm_i.address)
            MPF_OFS_TXCTRL: rd_nxt[1:0] = sw_pend_r;
            MPF_OFS_STATUS: begin
                rd_nxt[MPF_MAX_Q-1:0] = rx_priority_pause_flags_o;
                rd_nxt[MPF_ST_PAUSED] = tx_paused_o;
            end
            MPF_OFS_DUR:    rd_nxt[15:0] = dur_r;
            MPF_OFS_CFG: begin
                rd_nxt[3:0]            = 4'(NUM_Q);
                rd_nxt[MPF_CFG_PFC]    = PFC_EN;
                rd_nxt[MPF_CFG_TXONLY] = TX_ONLY;
            end
            default:        rd_nxt = MPF_RST_WORD;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mm_readdata_o <= MPF_RST_WORD;
        end else if (mm_i.read && bus_st_r == MPF_BUS_IDLE) begin
            mm_readdata_o <= rd_nxt;
        end
    end

    // Software pause request, cleared once issued; a new write wins the clear
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sw_pend_r <= MPF_RST_CTRL;
        end else if (wr_take && mm_i.address == MPF_OFS_TXCTRL && mm_i.byteenable[0]) begin
            sw_pend_r <= mm_i.writedata[1:0];
        end else begin
            sw_pend_r <= MPF_RST_CTRL;
        end
    end

    // Standard pause frame command
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pause_gen_o <= '0;
        end else if (sw_pend_r != MPF_RST_CTRL) begin
            pause_gen_o.xon  <= sw_pend_r[MPF_CTRL_XON];
            pause_gen_o.xoff <= sw_pend_r[MPF_CTRL_XOFF];
        end else begin
            pause_gen_o.xon  <= pause_frame_request_i[MPF_REQ_XON];
            pause_gen_o.xoff <= pause_frame_request_i[MPF_REQ_XOFF];
        end
    end

    // Per-queue receive pause timers
    logic [MPF_MAX_Q-1:0][MPF_TMR_W-1:0] rx_tmr_r;
    logic [MPF_MAX_Q-1:0][MPF_TMR_W-1:0] rx_tmr_nxt;
    logic [MPF_MAX_Q-1:0]                rx_load;

    always_comb begin
        for (int n = 0; n < MPF_MAX_Q; n++) begin
            rx_load[n]    = PFC_EN && Q_MASK[n] && rx_pfc_frame_i.valid
                            && rx_pfc_frame_i.enable[n];
            rx_tmr_nxt[n] = tmr_step(rx_tmr_r[n]);
            if (rx_load[n]) begin
                // Zero quanta loads zero and so drops the flag
                rx_tmr_nxt[n] = quanta_to_cycles(rx_pfc_frame_i.quanta[n]);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_tmr_r                  <= '0;
            rx_priority_pause_flags_o <= '0;
        end else begin
            rx_tmr_r <= rx_tmr_nxt;
            for (int n = 0; n < MPF_MAX_Q; n++) begin
                rx_priority_pause_flags_o[n] <= (rx_tmr_nxt[n] != MPF_RST_TMR);
            end
        end
    end

    // Per-queue transmit XON/XOFF requests; even bit XON, odd bit XOFF
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_pfc_xon_o  <= '0;
            tx_pfc_xoff_o <= '0;
        end else begin
            for (int n = 0; n < MPF_MAX_Q; n++) begin
                tx_pfc_xon_o[n]  <= PFC_EN && Q_MASK[n]
                                    && tx_priority_xon_xoff_request_i[2*n]
                                    && !tx_priority_xon_xoff_request_i[2*n+1];
                tx_pfc_xoff_o[n] <= PFC_EN && Q_MASK[n]
                                    && tx_priority_xon_xoff_request_i[2*n+1]
                                    && !tx_priority_xon_xoff_request_i[2*n];
            end
        end
    end

    // Transmit-only build: sampled received pause duration holds transmit off
    logic                 dur_take;
    logic [MPF_TMR_W-1:0] tx_tmr_r;
    logic [MPF_TMR_W-1:0] tx_tmr_nxt;

    assign dur_take   = TX_ONLY && rx_pause_duration_valid_i;
    assign tx_tmr_nxt = dur_take ? quanta_to_cycles(rx_pause_duration_in_i)
                                 : tmr_step(tx_tmr_r);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dur_r <= '0;
        end else if (dur_take) begin
            dur_r <= rx_pause_duration_in_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_tmr_r    <= MPF_RST_TMR;
            tx_paused_o <= 1'b0;
        end else begin
            tx_tmr_r    <= tx_tmr_nxt;
            tx_paused_o <= (tx_tmr_nxt != MPF_RST_TMR);
        end
    end

    // Checks
    AST_REG_WINS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (sw_pend_r != MPF_RST_CTRL) |=> (pause_gen_o == $past(sw_pend_r)))
        else $error("Register request did not win");

    AST_PAUSE_REQ: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (sw_pend_r == MPF_RST_CTRL) |=> (pause_gen_o == $past(pause_frame_request_i)))
        else $error("Pause input not forwarded");

    AST_RX_SET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (rx_load[0] && rx_pfc_frame_i.quanta[0] != 16'h0000)
        |=> (rx_priority_pause_flags_o[0]
             && rx_tmr_r[0] == {$past(rx_pfc_frame_i.quanta[0]), 3'b000}))
        else $error("Queue 0 pause not set with quanta times eight");

    AST_RX_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (rx_load[0] && rx_pfc_frame_i.quanta[0] == 16'h0001) ##1 (!rx_load[0])[*8]
        |-> rx_priority_pause_flags_o[0] ##1 !rx_priority_pause_flags_o[0])
        else $error("Queue 0 pause length wrong for one quantum");

    AST_RX_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (rx_load[0] && rx_pfc_frame_i.quanta[0] == 16'h0000)
        |=> !rx_priority_pause_flags_o[0])
        else $error("Zero quanta did not clear queue 0");

    AST_RX_EXPIRE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (rx_tmr_r[0] == MPF_TMR_W'(1) && !rx_load[0])
        |=> (!rx_priority_pause_flags_o[0] && rx_tmr_r[0] == MPF_RST_TMR))
        else $error("Queue 0 timer expiry did not clear");

    AST_TX_XON: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (PFC_EN && tx_priority_xon_xoff_request_i[1:0] == 2'b01)
        |=> (tx_pfc_xon_o[0] && !tx_pfc_xoff_o[0]))
        else $error("Queue 0 XON not issued from bit 0");

    AST_TX_XOFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (PFC_EN && NUM_Q > 1 && tx_priority_xon_xoff_request_i[3:2] == 2'b10)
        |=> (tx_pfc_xoff_o[1] && !tx_pfc_xon_o[1]))
        else $error("Queue 1 XOFF not issued from bit 3");

    AST_TX_BOTH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (tx_priority_xon_xoff_request_i[1:0] == 2'b11)
        |=> (!tx_pfc_xon_o[0] && !tx_pfc_xoff_o[0]))
        else $error("Both bits set produced a request");

    AST_DUR_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !rx_pause_duration_valid_i |=> $stable(dur_r))
        else $error("Duration changed without qualifier");

    AST_DUR_VARIANT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !TX_ONLY |-> (dur_r == 16'h0000 && !tx_paused_o))
        else $error("Duration used outside transmit-only build");

    AST_PFC_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!PFC_EN || NUM_Q < MPF_MAX_Q)
        |-> ((rx_priority_pause_flags_o & ~Q_MASK) == '0 && (tx_pfc_xon_o & ~Q_MASK) == '0))
        else $error("Priority signal active outside configured queues");

    AST_BUS_ACK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (acc_req && bus_st_r == MPF_BUS_IDLE) |-> mm_waitrequest_o ##1 !mm_waitrequest_o)
        else $error("Bus access not answered after one wait state");

    AST_PAUSE_XOFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (sw_pend_r == MPF_RST_CTRL && pause_frame_request_i == 2'b10)
        |=> (pause_gen_o.xoff && !pause_gen_o.xon))
        else $error("Pause input XOFF not forwarded");

    AST_WR_TAKE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_take && mm_i.address == MPF_OFS_TXCTRL && mm_i.byteenable[0])
        |=> (sw_pend_r == $past(mm_i.writedata[1:0])))
        else $error("Pause control write not taken");

    AST_PEND_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (sw_pend_r != MPF_RST_CTRL && !wr_take) |=> (sw_pend_r == MPF_RST_CTRL))
        else $error("Software pause request did not clear");

    AST_RX_SET_Q1: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (rx_load[1] && rx_pfc_frame_i.quanta[1] != 16'h0000)
        |=> rx_priority_pause_flags_o[1])
        else $error("Queue 1 pause not set");

    AST_RX_UNTOUCHED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (rx_pfc_frame_i.valid && !rx_pfc_frame_i.enable[0])
        |=> (rx_tmr_r[0] == tmr_step($past(rx_tmr_r[0]))))
        else $error("Disabled queue 0 timer disturbed by frame");

    AST_RX_KEEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!rx_load[0] && rx_tmr_r[0] > MPF_TMR_W'(1)) |=> rx_priority_pause_flags_o[0])
        else $error("Queue 0 pause dropped before timer ran out");

    AST_TX_NONE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (tx_priority_xon_xoff_request_i == '0)
        |=> (tx_pfc_xon_o == '0 && tx_pfc_xoff_o == '0))
        else $error("Request issued without request bits");

    AST_TX_XON_Q7: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (PFC_EN && NUM_Q == MPF_MAX_Q && tx_priority_xon_xoff_request_i[15:14] == 2'b01)
        |=> (tx_pfc_xon_o[7] && !tx_pfc_xoff_o[7]))
        else $error("Queue 7 XON not issued from bit 14");

    AST_TX_BOTH_Q7: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (tx_priority_xon_xoff_request_i[15:14] == 2'b11)
        |=> (!tx_pfc_xon_o[7] && !tx_pfc_xoff_o[7]))
        else $error("Queue 7 both bits set produced a request");

    AST_TX_LOAD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (dur_take && rx_pause_duration_in_i != 16'h0000)
        |=> (tx_paused_o && tx_tmr_r == {$past(rx_pause_duration_in_i), 3'b000}))
        else $error("Sampled duration not loaded as quanta times eight");

    AST_TXP_EXPIRE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (tx_tmr_r == MPF_TMR_W'(1) && !dur_take)
        |=> (!tx_paused_o && tx_tmr_r == MPF_RST_TMR))
        else $error("Transmit hold-off did not end");

    AST_DUR_SAMPLE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        dur_take |=> (dur_r == $past(rx_pause_duration_in_i)))
        else $error("Qualified duration not sampled");

    AST_BUS_IDLE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !acc_req |-> !mm_waitrequest_o)
        else $error("Stall raised without a request");

    AST_CFG_READ: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (mm_i.read && bus_st_r == MPF_BUS_IDLE && mm_i.address == MPF_OFS_CFG)
        |=> (mm_readdata_o[3:0] == 4'(NUM_Q) && mm_readdata_o[MPF_CFG_PFC] == PFC_EN
             && mm_readdata_o[MPF_CFG_TXONLY] == TX_ONLY))
        else $error("Configuration read wrong");

    AST_STATUS_READ: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (mm_i.read && bus_st_r == MPF_BUS_IDLE && mm_i.address == MPF_OFS_STATUS)
        |=> (mm_readdata_o[MPF_MAX_Q-1:0] == $past(rx_priority_pause_flags_o)
             && mm_readdata_o[MPF_ST_PAUSED] == $past(tx_paused_o)))
        else $error("Status read wrong");

    AST_DUR_READ: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (mm_i.read && bus_st_r == MPF_BUS_IDLE && mm_i.address == MPF_OFS_DUR)
        |=> (mm_readdata_o[15:0] == $past(dur_r)))
        else $error("Duration read wrong");

    COV_SW_PAUSE: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        wr_take && mm_i.address == MPF_OFS_TXCTRL ##2 pause_gen_o.xoff);
    COV_RX_EXPIRE: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        $fell(rx_priority_pause_flags_o[0]) && !$past(rx_load[0]));
    COV_TX_BOTH: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        tx_priority_xon_xoff_request_i[1:0] == 2'b11);
    COV_DUR: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        dur_take ##1 tx_paused_o);
    COV_RX_HOLD: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        rx_load[0] && rx_pfc_frame_i.quanta[0] == 16'h0001);

endmodule // mpf_flow_ctrl

// file: verification/mpf_client_model.sv
// Client-side model that drives the flow-control sideband inputs
module mpf_client_model (
    input  wire logic               clk_i,       // Client clock
    output logic [1:0]              pause_o,     // Pause frame ask
    output logic [15:0]             pfc_req_o,   // Per queue XON/XOFF pairs
    output mpf_pkg::mpf_pfc_frame_t frame_o,     // Parsed PFC frame pulse
    output logic [15:0]             dur_o,       // Pause duration in quanta
    output logic                    dur_vld_o    // Duration qualifier
);
    timeunit 1ns;
    timeprecision 1ps;
    import mpf_pkg::*;
    logic [15:0] dur_val;
    logic        dur_go;
    initial begin
        pause_o = 2'h0;
        pfc_req_o = 16'h0000;
        frame_o = '0;
        dur_o = 16'hA5A5;
        dur_vld_o = 1'b0;
        dur_val = 16'h0000;
        dur_go = 1'b0;
    end
    // Duration is meaningful only under the qualifier; otherwise it keeps toggling
    always @(posedge clk_i) begin
        dur_vld_o <= dur_go;
        dur_o     <= dur_go ? dur_val : ~dur_o;
    end
    task automatic set_req(input logic [1:0] p, input logic [15:0] t);
        @(posedge clk_i);
        pause_o   <= p;
        pfc_req_o <= t;
    endtask
    task automatic send_frame(input logic [7:0] en, input logic [127:0] q);
        @(posedge clk_i);
        frame_o <= {1'b1, en, q};
        @(posedge clk_i);
        frame_o <= {1'b0, ~en, ~q};
    endtask
    task automatic send_duration(input logic [15:0] d);
        @(posedge clk_i);
        dur_val <= d;
        dur_go  <= 1'b1;
        @(posedge clk_i);
        dur_go  <= 1'b0;
    endtask
endmodule // mpf_client_model

// file: verification/testbench.sv
// Self-checking testbench for the pause flow-control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mpf_pkg::*;
    typedef struct packed {
        logic [1:0]  p;
        logic [15:0] t;
        logic [1:0]  g;
        logic [7:0]  on;
        logic [7:0]  off;
    } mpf_row_t;
    logic                   clk_i   = 1'b0;
    logic                   rst_b_i = 1'b0;
    mpf_mm_req_t            mm_i    = '0;
    logic [31:0]            rdata;
    logic [31:0]            rd;
    logic                   wreq;
    mpf_pause_gen_t         gen;
    logic [7:0]             flags;
    logic [7:0]             xon;
    logic [7:0]             xoff;
    logic                   paused;
    logic [1:0]             pause;
    logic [15:0]            pfc;
    mpf_pfc_frame_t         frame;
    logic [15:0]            dur;
    logic                   dur_vld;
    int                     error_cnt = 0;
    int                     n_checks  = 0;
    int                     cyc       = 0;
    int                     cnt;
    mpf_row_t rows[7] = '{'{2'h1, 16'h0001, 2'h1, 8'h01, 8'h00},
                          '{2'h2, 16'h0002, 2'h2, 8'h00, 8'h01},
                          '{2'h0, 16'h5555, 2'h0, 8'hFF, 8'h00},
                          '{2'h0, 16'hAAAA, 2'h0, 8'h00, 8'hFF},
                          '{2'h0, 16'hFFFF, 2'h0, 8'h00, 8'h00},
                          '{2'h1, 16'h8001, 2'h1, 8'h01, 8'h80},
                          '{2'h2, 16'h0C06, 2'h2, 8'h02, 8'h01}};
    always #10 clk_i = ~clk_i;
    mpf_flow_ctrl #(.PFC_EN(1'b1), .NUM_Q(8), .TX_ONLY(1'b1)) dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .mm_i(mm_i), .mm_readdata_o(rdata),
        .mm_waitrequest_o(wreq), .pause_frame_request_i(pause), .pause_gen_o(gen),
        .rx_pfc_frame_i(frame), .rx_priority_pause_flags_o(flags),
        .tx_priority_xon_xoff_request_i(pfc), .tx_pfc_xon_o(xon), .tx_pfc_xoff_o(xoff),
        .rx_pause_duration_in_i(dur), .rx_pause_duration_valid_i(dur_vld),
        .tx_paused_o(paused));
    mpf_client_model client (
        .clk_i(clk_i), .pause_o(pause), .pfc_req_o(pfc), .frame_o(frame),
        .dur_o(dur), .dur_vld_o(dur_vld));
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        mm_i <= '{read: !w, write: w, address: a, byteenable: 4'hF, writedata: d};
        do @(posedge clk_i); while (wreq !== 1'b0);
        rd = rdata;
        mm_i <= '0;
    endtask
    // Counts cycles of a flag, tx hold-off, or a lone XOFF command over n cycles
    task automatic measure(input int sel, input int n);
        cnt = 0;
        repeat (n) begin
            @(negedge clk_i);
            if ((sel < 8 ? flags[sel] : sel == 8 ? paused : gen === 2'h2) === 1'b1)
                cnt++;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk({gen, xon, xoff, flags, paused}, 32'h0000_0000);
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        foreach (rows[i]) begin
            client.set_req(rows[i].p, rows[i].t);
            @(posedge clk_i);
            @(negedge clk_i);
            chk(gen, rows[i].g);
            chk(xon, rows[i].on);
            chk(xoff, rows[i].off);
        end
        client.set_req(2'h1, 16'h0000);
        bus(1'b1, MPF_OFS_TXCTRL, 32'h0000_0002);
        measure(9, 6);
        chk(cnt, 1);
        bus(1'b0, MPF_OFS_TXCTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(1'b0, MPF_OFS_CFG, 32'h0000_0000);
        chk(rd, 32'h0000_0308);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF);
        bus(1'b0, 4'h2, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(1'b1, MPF_OFS_STATUS, 32'hFFFF_FFFF);
        bus(1'b0, MPF_OFS_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        client.set_req(2'h0, 16'h0000);
        client.send_frame(8'h06, {64'h0, 16'h0005, 16'h0064, 16'h0002, 16'h0000});
        measure(1, 30);
        chk(cnt, 16);
        chk(flags, 8'h04);
        client.send_frame(8'h04, 128'h0);
        @(posedge clk_i);
        @(negedge clk_i);
        chk(flags, 8'h00);
        client.send_frame(8'h01, {112'h0, 16'h0032});
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        @(negedge clk_i);
        chk(flags, 8'h00);
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        measure(0, 10);
        chk(cnt, 0);
        client.send_frame(8'h01, {112'h0, 16'h0001});
        measure(0, 12);
        chk(cnt, 8);
        client.send_frame(8'h01, {112'h0, 16'h0032});
        @(negedge clk_i);
        chk(flags, 8'h01);
        client.send_frame(8'h01, 128'h0);
        @(negedge clk_i);
        chk(flags, 8'h00);
        client.send_duration(16'h0003);
        measure(8, 40);
        chk(cnt, 24);
        bus(1'b0, MPF_OFS_DUR, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        stop_test();
    end
endmodule // testbench
